//--- src/efs_regs.vh
// Register map, field positions, reset values and timing for the encoder supervisor
`ifndef EFS_REGS_VH
`define EFS_REGS_VH

// Register byte offsets
`define EFS_CTRL 8'h00
`define EFS_PULSES_PER_REV 8'h04
`define EFS_STOP_SEL 8'h08
`define EFS_MONITOR_DIV 8'h0c
`define EFS_OVERSPEED_LEVEL 8'h10
`define EFS_OVERSPEED_DELAY 8'h14
`define EFS_DEVIATION_LEVEL 8'h18
`define EFS_DEVIATION_DELAY 8'h1c
`define EFS_MOTOR_TEETH 8'h20
`define EFS_LOAD_TEETH 8'h24
`define EFS_OPEN_TIME 8'h28
`define EFS_AGREE_WIDTH 8'h2c
`define EFS_MAX_SPEED 8'h30
`define EFS_STATUS 8'h34
`define EFS_SPEED 8'h38

// Control fields
`define EFS_CTRL_INTEG_BIT 0
`define EFS_CTRL_DIR_BIT 1
// Stop selection fields
`define EFS_SEL_OPEN_LSB 0
`define EFS_SEL_OVER_LSB 2
`define EFS_SEL_DEV_LSB 4
// Status fields
`define EFS_ST_OVER_BIT 0
`define EFS_ST_DEV_BIT 1
`define EFS_ST_OPEN_BIT 2
`define EFS_ST_AGREE_BIT 3
`define EFS_ST_REV_BIT 4
`define EFS_ST_STOPREQ_BIT 5
`define EFS_ST_METHOD_LSB 6

// Reset values
`define EFS_RST_INTEG 1'h0
`define EFS_RST_DIR 1'h0
`define EFS_RST_PPR 16'h0258
`define EFS_RST_OPEN_SEL 2'h1
`define EFS_RST_OVER_SEL 2'h1
`define EFS_RST_DEV_SEL 2'h3
`define EFS_RST_DIV 8'h01
`define EFS_RST_OVER_LEVEL 8'h73
`define EFS_RST_OVER_DELAY 8'h00
`define EFS_RST_DEV_LEVEL 8'h0a
`define EFS_RST_DEV_DELAY 8'h05
`define EFS_RST_TEETH 10'h000
`define EFS_RST_OPEN_TIME 8'h14
`define EFS_RST_AGREE 16'h001e
`define EFS_RST_MAX_SPEED 16'h0708

// Setting limits
`define EFS_MAX_PPR 16'hea60
`define EFS_MAX_TEETH 10'h3e8
`define EFS_MAX_OVER_LEVEL 8'h78
`define EFS_MAX_OVER_DELAY 8'h14
`define EFS_MAX_DEV_LEVEL 8'h32
`define EFS_MAX_LONG_DELAY 8'h64
`define EFS_MAX_DIV 8'h84
`define EFS_DIV_N_STEP 8'h64
`define EFS_MIN_REF_PCT 8'h01

// Stop methods
`define EFS_STOP_RAMP 2'h0
`define EFS_STOP_COAST 2'h1
`define EFS_STOP_FAST 2'h2
`define EFS_STOP_CONT 2'h3

// Timing: one gate/timer tick is 0.1 s
`define EFS_TICK_NS 100000000
`define EFS_CLK_NS 25
`define EFS_TICK_CYCLES (`EFS_TICK_NS / `EFS_CLK_NS)
`define EFS_RPM_SCALE 36'h258
`define EFS_PCT_SCALE 32'h64

`endif

//--- src/efs_pulse_div.v
// Pulse monitor divider: passes (1+n)/m of the encoder pulses
`timescale 1ns/10ps
module efs_pulse_div (
  input wire clk_in,
  input wire sys_rst_in,
  input wire phase_a_in,
  input wire a_rise_in,
  input wire two_phase_card_in,
  input wire [7:0] ratio_in,
  output reg monitor_out
);
  `include "efs_regs.vh"

  reg [5:0] acc;
  reg pass;
  reg [1:0] num;
  reg [5:0] den;
  reg [6:0] sum;
  reg [7:0] m_digits;
  reg [6:0] left;

  // Split the setting into the n and m digits
  always @* begin
    num = 2'h1;
    den = 6'h01;
    m_digits = ratio_in;
    if (two_phase_card_in) begin
      if (ratio_in >= `EFS_DIV_N_STEP) begin
        num = 2'h2;
        m_digits = ratio_in - `EFS_DIV_N_STEP;
      end
      den = m_digits > 8'h20 ? 6'h20 : m_digits[5:0];
      if (den == 6'h00) begin
        den = 6'h01;
      end
    end
    sum = {1'b0, acc} + {5'h00, num};
    left = sum - {1'b0, den};
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      acc <= 6'h00;
      pass <= 1'b0;
      monitor_out <= 1'b0;
    end else begin
      if (a_rise_in) begin
        // Ratio never above one: at most one output per input pulse
        if (sum >= {1'b0, den}) begin
          pass <= 1'b1;
          acc <= (left >= {1'b0, den}) ? 6'h00 : left[5:0];
        end else begin
          pass <= 1'b0;
          acc <= sum[5:0];
        end
      end
      monitor_out <= phase_a_in & (a_rise_in ? (sum >= {1'b0, den}) : pass);
    end
  end
endmodule

//--- src/efs_top.v
// Encoder feedback supervisor: speed, monitor output, fault timers, stop selection
//
// Function
// - Monitor output divides encoder pulses by (1+n)/m
// - Divider setting 1..132, ratio 1/32..1, default 1
// - Division only with two-phase card fitted
// - Integral suspended during ramps when selection zero
// - Overspeed when above level longer than delay
// - Overspeed delay settable 0.0 to 2.0 s
// - Overspeed fault stops with overspeed stop selection
// - Deviation when gap exceeds level past delay
// - Deviation armed only after speed agreement
// - Deviation fault acts per deviation stop selection
// - Open circuit when running, feedback missing too long
// - Speed rpm equals pulses times 60 over ppr
// - Zero teeth setting gives unity gear ratio
// - Stop codes ramp, coast, fast, continue
// - Open circuit stop selection defaults to coast
// - Rotation selection picks leading phase as forward
// - Pulses per revolution 0..60000, default 600
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`include "efs_regs.vh"
module efs_top #(
  parameter TICK_CYCLES = `EFS_TICK_CYCLES
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire phase_a_in,
  input wire phase_b_in,
  input wire two_phase_card_in,
  input wire run_in,
  input wire dc_brake_in,
  input wire ramping_in,
  input wire [15:0] ref_speed_in,
  output reg monitor_pulse_out,
  output reg integral_enable_out,
  output reg reverse_out,
  output reg [15:0] motor_speed_out,
  output reg overspeed_fault_out,
  output reg speed_deviation_fault_out,
  output reg encoder_open_circuit_out,
  output reg speed_agree_out,
  output reg stop_request_out,
  output reg [1:0] stop_method_out
);
  function [15:0] abs_diff;
    input [15:0] a;
    input [15:0] b;
    begin
      abs_diff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // True when value is above pct percent of full scale
  function above_pct;
    input [15:0] value;
    input [7:0] pct;
    input [15:0] full;
    begin
      above_pct = ({16'h0000, value} * `EFS_PCT_SCALE) > ({24'h000000, pct} * {16'h0000, full});
    end
  endfunction

  function [7:0] clamp8;
    input [31:0] value;
    input [7:0] limit;
    begin
      clamp8 = (value > {24'h000000, limit}) ? limit : value[7:0];
    end
  endfunction

  // Delay timer in ticks: restarts whenever its condition clears
  function [7:0] next_timer;
    input [7:0] cnt;
    input cond;
    input tick;
    begin
      if (!cond) begin
        next_timer = 8'h00;
      end else if (tick && cnt != 8'hff) begin
        next_timer = cnt + 8'h01;
      end else begin
        next_timer = cnt;
      end
    end
  endfunction

  // Settings
  reg integ_sel;
  reg dir_sel;
  reg [15:0] ppr;
  reg [1:0] open_sel;
  reg [1:0] over_sel;
  reg [1:0] dev_sel;
  reg [7:0] div_ratio;
  reg [7:0] over_level;
  reg [7:0] over_delay;
  reg [7:0] dev_level;
  reg [7:0] dev_delay;
  reg [9:0] motor_teeth;
  reg [9:0] load_teeth;
  reg [7:0] open_time;
  reg [15:0] agree_width;
  reg [15:0] max_speed;

  // Bus slave: request waits one cycle, answered on the second edge
  wire bus_req = avs_read_in | avs_write_in;
  wire bus_wr = avs_write_in & ~avs_waitrequest_out;
  wire [31:0] wd = avs_writedata_in;
  wire status_clr = bus_wr && avs_address_in == `EFS_STATUS;
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = 32'h00000000;
    case (avs_address_in)
      `EFS_CTRL: next_rdata = {30'h0, dir_sel, integ_sel};
      `EFS_PULSES_PER_REV: next_rdata = {16'h0000, ppr};
      `EFS_STOP_SEL: next_rdata = {26'h0, dev_sel, over_sel, open_sel};
      `EFS_MONITOR_DIV: next_rdata = {24'h0, div_ratio};
      `EFS_OVERSPEED_LEVEL: next_rdata = {24'h0, over_level};
      `EFS_OVERSPEED_DELAY: next_rdata = {24'h0, over_delay};
      `EFS_DEVIATION_LEVEL: next_rdata = {24'h0, dev_level};
      `EFS_DEVIATION_DELAY: next_rdata = {24'h0, dev_delay};
      `EFS_MOTOR_TEETH: next_rdata = {22'h0, motor_teeth};
      `EFS_LOAD_TEETH: next_rdata = {22'h0, load_teeth};
      `EFS_OPEN_TIME: next_rdata = {24'h0, open_time};
      `EFS_AGREE_WIDTH: next_rdata = {16'h0000, agree_width};
      `EFS_MAX_SPEED: next_rdata = {16'h0000, max_speed};
      `EFS_STATUS: next_rdata = {24'h0, stop_method_out, stop_request_out, reverse_out,
        speed_agree_out, encoder_open_circuit_out, speed_deviation_fault_out,
        overspeed_fault_out};
      `EFS_SPEED: next_rdata = {16'h0000, motor_speed_out};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
      integ_sel <= `EFS_RST_INTEG;
      dir_sel <= `EFS_RST_DIR;
      ppr <= `EFS_RST_PPR;
      open_sel <= `EFS_RST_OPEN_SEL;
      over_sel <= `EFS_RST_OVER_SEL;
      dev_sel <= `EFS_RST_DEV_SEL;
      div_ratio <= `EFS_RST_DIV;
      over_level <= `EFS_RST_OVER_LEVEL;
      over_delay <= `EFS_RST_OVER_DELAY;
      dev_level <= `EFS_RST_DEV_LEVEL;
      dev_delay <= `EFS_RST_DEV_DELAY;
      motor_teeth <= `EFS_RST_TEETH;
      load_teeth <= `EFS_RST_TEETH;
      open_time <= `EFS_RST_OPEN_TIME;
      agree_width <= `EFS_RST_AGREE;
      max_speed <= `EFS_RST_MAX_SPEED;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      if (bus_req & avs_waitrequest_out) begin
        avs_readdata_out <= avs_read_in ? next_rdata : 32'h00000000;
      end
      if (bus_wr) begin
        case (avs_address_in)
          `EFS_CTRL: begin
            integ_sel <= wd[`EFS_CTRL_INTEG_BIT];
            dir_sel <= wd[`EFS_CTRL_DIR_BIT];
          end
          `EFS_PULSES_PER_REV: ppr <= (wd > {16'h0, `EFS_MAX_PPR}) ? `EFS_MAX_PPR : wd[15:0];
          `EFS_STOP_SEL: begin
            open_sel <= wd[`EFS_SEL_OPEN_LSB +: 2];
            over_sel <= wd[`EFS_SEL_OVER_LSB +: 2];
            dev_sel <= wd[`EFS_SEL_DEV_LSB +: 2];
          end
          `EFS_MONITOR_DIV: begin
            if (wd >= 32'h1 && wd <= {24'h0, `EFS_MAX_DIV}) begin
              div_ratio <= wd[7:0];
            end
          end
          `EFS_OVERSPEED_LEVEL: over_level <= clamp8(wd, `EFS_MAX_OVER_LEVEL);
          `EFS_OVERSPEED_DELAY: over_delay <= clamp8(wd, `EFS_MAX_OVER_DELAY);
          `EFS_DEVIATION_LEVEL: dev_level <= clamp8(wd, `EFS_MAX_DEV_LEVEL);
          `EFS_DEVIATION_DELAY: dev_delay <= clamp8(wd, `EFS_MAX_LONG_DELAY);
          `EFS_MOTOR_TEETH: motor_teeth <= (wd > {22'h0, `EFS_MAX_TEETH}) ? `EFS_MAX_TEETH : wd[9:0];
          `EFS_LOAD_TEETH: load_teeth <= (wd > {22'h0, `EFS_MAX_TEETH}) ? `EFS_MAX_TEETH : wd[9:0];
          `EFS_OPEN_TIME: open_time <= clamp8(wd, `EFS_MAX_LONG_DELAY);
          `EFS_AGREE_WIDTH: agree_width <= wd[15:0];
          `EFS_MAX_SPEED: max_speed <= wd[15:0];
          default: ;
        endcase
      end
    end
  end

  // Encoder edges and direction
  reg a_prev;
  wire a_rise = phase_a_in & ~a_prev;
  reg [31:0] tick_cnt;
  wire tick = (tick_cnt == TICK_CYCLES - 1);
  reg [15:0] gate_cnt;
  reg [15:0] gate_last;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      // Start from the pin level so reset makes no false edge
      a_prev <= phase_a_in;
      tick_cnt <= 32'h00000000;
      gate_cnt <= 16'h0000;
      gate_last <= 16'h0000;
      reverse_out <= 1'b0;
    end else begin
      a_prev <= phase_a_in;
      tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
      if (tick) begin
        gate_last <= gate_cnt;
        gate_cnt <= {15'h0000, a_rise};
      end else if (a_rise && gate_cnt != 16'hffff) begin
        gate_cnt <= gate_cnt + 16'h0001;
      end
      // B low at A rise means A leads
      if (a_rise) begin
        reverse_out <= two_phase_card_in & (phase_b_in ^ dir_sel);
      end
    end
  end

  // Speed: pulses per gate x 600 / ppr x load / motor, sequential divide
  wire unity_gear = (motor_teeth == 10'h000) || (load_teeth == 10'h000);
  wire [35:0] load_eff = unity_gear ? 36'h1 : {26'h0, load_teeth};
  wire [25:0] motor_eff = unity_gear ? 26'h1 : {16'h0, motor_teeth};
  wire [35:0] numer = {20'h0, gate_last} * `EFS_RPM_SCALE * load_eff;
  wire [25:0] denom = {10'h0, ppr} * motor_eff;
  reg [35:0] div_quo;
  reg [36:0] div_rem;
  reg [25:0] div_den;
  reg [5:0] div_cnt;
  reg div_busy;
  reg start_div;
  wire [36:0] rem_sh = {div_rem[35:0], div_quo[35]};
  wire rem_ge = rem_sh >= {11'h000, div_den};

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      start_div <= 1'b0;
      div_busy <= 1'b0;
      div_quo <= 36'h0;
      div_rem <= 37'h0;
      div_den <= 26'h0;
      div_cnt <= 6'h00;
      motor_speed_out <= 16'h0000;
    end else begin
      start_div <= tick;
      if (start_div) begin
        if (denom == 26'h0) begin
          motor_speed_out <= 16'h0000;
        end else begin
          div_busy <= 1'b1;
          div_quo <= numer;
          div_rem <= 37'h0;
          div_den <= denom;
          div_cnt <= 6'h00;
        end
      end else if (div_busy) begin
        div_rem <= rem_ge ? rem_sh - {11'h000, div_den} : rem_sh;
        div_quo <= {div_quo[34:0], rem_ge};
        div_cnt <= div_cnt + 6'h01;
        if (div_cnt == 6'h23) begin
          div_busy <= 1'b0;
          motor_speed_out <= (div_quo[34:15] != 20'h0) ? 16'hffff : {div_quo[14:0], rem_ge};
        end
      end
    end
  end

  // Fault detection
  wire [15:0] gap = abs_diff(ref_speed_in, motor_speed_out);
  wire over_cond = above_pct(motor_speed_out, over_level, max_speed);
  wire agree_now = run_in && gap <= agree_width;
  reg dev_armed;
  wire dev_cond = dev_armed && above_pct(gap, dev_level, max_speed);
  wire ref_ok = ({16'h0, ref_speed_in} * `EFS_PCT_SCALE) >=
    ({24'h0, `EFS_MIN_REF_PCT} * {16'h0, max_speed});
  wire open_cond = run_in && !dc_brake_in && ref_ok && gate_last == 16'h0000;
  wire mon_pulse;
  reg [7:0] over_tmr;
  reg [7:0] dev_tmr;
  reg [7:0] open_tmr;
  wire over_set = over_cond && over_tmr >= over_delay;
  wire dev_set = dev_cond && dev_tmr >= dev_delay;
  wire open_set = open_cond && open_tmr >= open_time;

  // Harshest stop method among the active faults
  reg [1:0] next_method;
  always @* begin
    next_method = `EFS_STOP_CONT;
    if (overspeed_fault_out && over_sel != `EFS_STOP_CONT) begin
      next_method = over_sel;
    end
    if (encoder_open_circuit_out && open_sel != `EFS_STOP_CONT &&
        (next_method == `EFS_STOP_CONT || open_sel == `EFS_STOP_COAST ||
        (open_sel == `EFS_STOP_FAST && next_method == `EFS_STOP_RAMP))) begin
      next_method = open_sel;
    end
    if (speed_deviation_fault_out && dev_sel != `EFS_STOP_CONT &&
        (next_method == `EFS_STOP_CONT || dev_sel == `EFS_STOP_COAST ||
        (dev_sel == `EFS_STOP_FAST && next_method == `EFS_STOP_RAMP))) begin
      next_method = dev_sel;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      dev_armed <= 1'b0;
      over_tmr <= 8'h00;
      dev_tmr <= 8'h00;
      open_tmr <= 8'h00;
      overspeed_fault_out <= 1'b0;
      speed_deviation_fault_out <= 1'b0;
      encoder_open_circuit_out <= 1'b0;
      speed_agree_out <= 1'b0;
      stop_request_out <= 1'b0;
      stop_method_out <= `EFS_STOP_CONT;
      integral_enable_out <= 1'b0;
      monitor_pulse_out <= 1'b0;
    end else begin
      dev_armed <= run_in && (dev_armed || agree_now);
      speed_agree_out <= agree_now;
      over_tmr <= next_timer(over_tmr, over_cond, tick);
      dev_tmr <= next_timer(dev_tmr, dev_cond, tick);
      open_tmr <= next_timer(open_tmr, open_cond, tick);
      // Sticky faults; a new event wins over a clear in the same cycle
      overspeed_fault_out <= over_set |
        (overspeed_fault_out & ~(status_clr & wd[`EFS_ST_OVER_BIT]));
      speed_deviation_fault_out <= dev_set |
        (speed_deviation_fault_out & ~(status_clr & wd[`EFS_ST_DEV_BIT]));
      encoder_open_circuit_out <= open_set |
        (encoder_open_circuit_out & ~(status_clr & wd[`EFS_ST_OPEN_BIT]));
      stop_method_out <= next_method;
      stop_request_out <= (next_method != `EFS_STOP_CONT);
      integral_enable_out <= integ_sel | ~ramping_in;
      monitor_pulse_out <= mon_pulse;
    end
  end

  efs_pulse_div u_div (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .phase_a_in(phase_a_in),
    .a_rise_in(a_rise),
    .two_phase_card_in(two_phase_card_in),
    .ratio_in(div_ratio),
    .monitor_out(mon_pulse)
  );
endmodule

//--- verif/efs_encoder.sv
// Quadrature encoder model on the motor shaft
`timescale 1ns/10ps
module efs_encoder (
  input wire clk_in,
  input wire run_in,
  input wire rev_in,
  input wire [7:0] period_in,
  output logic phase_a_out,
  output logic phase_b_out
);
  logic [7:0] pos = 8'h00;
  logic [7:0] q;
  // Shaft position, one step a clock while turning
  always @(posedge clk_in) begin
    if (run_in && rev_in) begin
      pos <= (pos == 8'h00) ? period_in - 8'h01 : pos - 8'h01;
    end else if (run_in) begin
      pos <= (pos >= period_in - 8'h01) ? 8'h00 : pos + 8'h01;
    end
  end
  // Phase B lags A by a quarter period going forward
  always_comb begin
    q = period_in >> 2;
    phase_a_out = pos < (period_in >> 1);
    phase_b_out = (pos >= q ? pos - q : pos + period_in - q) < (period_in >> 1);
  end
endmodule

//--- verif/efs_top_asserts.sv
// Port checker for the encoder feedback supervisor
`timescale 1ns/10ps
module efs_asserts (
  input wire clk_in,
  input wire sys_rst_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire avs_waitrequest_out,
  input wire run_in,
  input wire dc_brake_in,
  input wire ramping_in,
  input wire integral_enable_out,
  input wire overspeed_fault_out,
  input wire speed_deviation_fault_out,
  input wire encoder_open_circuit_out,
  input wire speed_agree_out,
  input wire stop_request_out,
  input wire [1:0] stop_method_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  reg armed;
  // Agreement seen since the run began
  always @(posedge clk_in) begin
    if (sys_rst_in || !run_in) begin
      armed <= 1'b0;
    end else if (speed_agree_out) begin
      armed <= 1'b1;
    end
  end
  sequence s_taken;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  a_bus_ack_pulse: assert property (s_taken |=> s_ack)
    else $error("bus request not acknowledged");
  a_bus_no_spurious: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
    else $error("acknowledge without request");
  a_integ_constant: assert property (!ramping_in |=> integral_enable_out)
    else $error("integral off at constant speed");
  a_stop_cause: assert property (stop_request_out |->
    $past(overspeed_fault_out || speed_deviation_fault_out || encoder_open_circuit_out))
    else $error("stop request without fault");
  a_stop_method_match: assert property (stop_request_out == (stop_method_out != 2'h3))
    else $error("stop method and request disagree");
  a_agree_run: assert property (speed_agree_out |-> $past(run_in))
    else $error("agreement while stopped");
  a_dev_armed: assert property ($rose(speed_deviation_fault_out) |-> armed)
    else $error("deviation before agreement");
  a_open_gate: assert property ($rose(encoder_open_circuit_out) |-> $past(run_in && !dc_brake_in))
    else $error("open circuit while idle or braking");
  a_over_sticky: assert property (overspeed_fault_out && !avs_write_in && !$past(avs_write_in)
    |=> overspeed_fault_out)
    else $error("overspeed fault dropped");
endmodule
bind efs_top efs_asserts u_chk (.*);

//--- verif/efs_top_test.sv
// Self-checking bench for the encoder feedback supervisor
`timescale 1ns/10ps
module efs_top_test;
  localparam int TICK = 200;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out;
  logic avs_waitrequest_out, phase_a_in, phase_b_in, monitor_pulse_out, integral_enable_out;
  logic two_phase_card_in = 1'b0, run_in = 1'b0, dc_brake_in = 1'b0, ramping_in = 1'b0;
  logic [15:0] ref_speed_in = 16'h0000, motor_speed_out;
  logic reverse_out, overspeed_fault_out, speed_deviation_fault_out, encoder_open_circuit_out;
  logic speed_agree_out, stop_request_out, mon_prev = 1'b0;
  logic [1:0] stop_method_out;
  logic enc_run = 1'b0, enc_rev = 1'b0;
  logic [7:0] enc_period = 8'h14;
  int miscompares = 0, total_checks = 0, cycles = 0, mon_cnt = 0;

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  efs_top #(.TICK_CYCLES(TICK)) DUT (.*);
  efs_encoder u_enc (.clk_in(clk_in), .run_in(enc_run), .rev_in(enc_rev),
    .period_in(enc_period), .phase_a_out(phase_a_in), .phase_b_out(phase_b_in));

  always @(posedge clk_in) begin
    mon_prev <= monitor_pulse_out;
    if (monitor_pulse_out === 1'b1 && mon_prev === 1'b0) begin
      mon_cnt <= mon_cnt + 1;
    end
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One Avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= !wr;
    avs_write_in <= wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge clk_in);
    end
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e, what);
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge clk_in);
  endtask

  task automatic t_reset();
    logic [7:0] a [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h28, 8'h3c};
    logic [31:0] e [10] = '{32'h0, 32'h258, 32'h35, 32'h1, 32'h73, 32'h0, 32'ha, 32'h5,
      32'h14, 32'h0};
    for (int i = 0; i < 10; i++) begin
      rd_chk(a[i], e[i], "reset value");
    end
    check(stop_method_out, 32'h3, "idle method");
    wr(8'h0c, 32'h85);
    rd_chk(8'h0c, 32'h1, "divider range");
    wr(8'h10, 32'hff);
    rd_chk(8'h10, 32'h78, "level clamp");
    wr(8'h14, 32'hff);
    rd_chk(8'h14, 32'h14, "delay clamp");
    wr(8'h04, 32'hffff);
    rd_chk(8'h04, 32'hea60, "ppr clamp");
    wr(8'h3c, 32'h5);
    rd_chk(8'h3c, 32'h0, "unmapped");
    wr(8'h10, 32'h73);
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h258);
    wr(8'h30, 32'h64);
    $display("test reset done");
  endtask

  task automatic t_speed();
    enc_run <= 1'b1;
    ticks(3);
    check(motor_speed_out, 32'ha, "speed");
    wr(8'h20, 32'h2);
    wr(8'h24, 32'h4);
    ticks(3);
    check(motor_speed_out, 32'h14, "geared speed");
    wr(8'h24, 32'h0);
    ticks(3);
    check(motor_speed_out, 32'ha, "zero teeth");
    wr(8'h20, 32'h0);
    $display("test speed done");
  endtask

  task automatic t_over();
    wr(8'h10, 32'h64);
    wr(8'h04, 32'h6);
    ticks(3);
    for (int c = 0; c < 4; c++) begin
      wr(8'h08, c << 2);
      wr(8'h34, 32'h7);
      repeat (10) @(posedge clk_in);
      check(overspeed_fault_out, 32'h1, "overspeed");
      check(stop_method_out, c, "overspeed method");
      check(stop_request_out, c != 3, "overspeed stop");
    end
    wr(8'h14, 32'h14);
    wr(8'h04, 32'h258);
    ticks(3);
    wr(8'h34, 32'h7);
    wr(8'h04, 32'h6);
    ticks(12);
    wr(8'h04, 32'h258);
    ticks(3);
    wr(8'h04, 32'h6);
    ticks(15);
    check(overspeed_fault_out, 32'h0, "interrupted delay");
    ticks(9);
    check(overspeed_fault_out, 32'h1, "full delay");
    wr(8'h14, 32'h0);
    wr(8'h04, 32'h258);
    wr(8'h10, 32'h73);
    wr(8'h08, 32'h35);
    ticks(3);
    wr(8'h34, 32'h7);
    $display("test overspeed done");
  endtask

  task automatic t_dev();
    wr(8'h18, 32'h5);
    run_in <= 1'b1;
    ref_speed_in <= 16'h0032;
    ticks(10);
    check(speed_deviation_fault_out, 32'h0, "deviation unarmed");
    ref_speed_in <= 16'h000a;
    ticks(2);
    check(speed_agree_out, 32'h1, "agree");
    enc_period <= 8'h64;
    ticks(3);
    check(speed_deviation_fault_out, 32'h0, "deviation delay");
    ticks(6);
    check(speed_deviation_fault_out, 32'h1, "deviation");
    check(stop_request_out, 32'h0, "deviation continue");
    wr(8'h08, 32'h25);
    repeat (4) @(posedge clk_in);
    check(stop_method_out, 32'h2, "deviation fast");
    run_in <= 1'b0;
    enc_period <= 8'h14;
    wr(8'h08, 32'h35);
    wr(8'h34, 32'h7);
    $display("test deviation done");
  endtask

  task automatic t_open();
    wr(8'h28, 32'h3);
    enc_run <= 1'b0;
    dc_brake_in <= 1'b1;
    run_in <= 1'b1;
    ref_speed_in <= 16'h0032;
    ticks(8);
    check(encoder_open_circuit_out, 32'h0, "open in braking");
    dc_brake_in <= 1'b0;
    ref_speed_in <= 16'h0000;
    ticks(5);
    check(encoder_open_circuit_out, 32'h0, "open low reference");
    ref_speed_in <= 16'h0032;
    ticks(1);
    check(encoder_open_circuit_out, 32'h0, "open delay");
    ticks(5);
    check(encoder_open_circuit_out, 32'h1, "open circuit");
    check(stop_method_out, 32'h1, "open coast");
    run_in <= 1'b0;
    enc_run <= 1'b1;
    wr(8'h34, 32'h7);
    $display("test open done");
  endtask

  task automatic t_mon();
    logic [31:0] dv [4] = '{32'h2, 32'h84, 32'h1, 32'h2};
    logic cd [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    int ex [4] = '{16, 2, 32, 32};
    int c0;
    for (int i = 0; i < 4; i++) begin
      two_phase_card_in <= cd[i];
      wr(8'h0c, dv[i]);
      repeat (100) @(posedge clk_in);
      c0 = mon_cnt;
      repeat (640) @(posedge clk_in);
      check(mon_cnt - c0, ex[i], "monitor pulses");
    end
    two_phase_card_in <= 1'b1;
    repeat (100) @(posedge clk_in);
    check(reverse_out, 32'h0, "forward");
    enc_rev <= 1'b1;
    repeat (100) @(posedge clk_in);
    check(reverse_out, 32'h1, "reverse");
    wr(8'h00, 32'h2);
    repeat (100) @(posedge clk_in);
    check(reverse_out, 32'h0, "swapped phases");
    ramping_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check(integral_enable_out, 32'h0, "ramp integral off");
    wr(8'h00, 32'h1);
    repeat (3) @(posedge clk_in);
    check(integral_enable_out, 32'h1, "ramp integral on");
    $display("test monitor done");
  endtask

  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_speed();
    t_over();
    t_dev();
    t_open();
    t_mon();
    end_of_test();
  end
endmodule
